// ### hdl/bridge_window_pkg.sv
// constants, types and register map of the bridge memory window decoder
package bridge_window_pkg;

    // ****************************************************************
    // widths
    // ****************************************************************
    localparam int ADDR_W = 40;
    localparam int BLOCK_BITS = 20;
    localparam int FIELD_W = 12;
    localparam int FIELD_LSB = 4;
    localparam int HIGH_W = 32;
    localparam int HIGH_USED_W = ADDR_W - 32;
    localparam int TOP_W = ADDR_W - BLOCK_BITS;

    // ****************************************************************
    // configuration offsets (byte addresses)
    // ****************************************************************
    localparam logic [7:0] OFS_NONPREFETCH_BASE = 8'h20;
    localparam logic [7:0] OFS_NONPREFETCH_LIMIT = 8'h22;
    localparam logic [7:0] OFS_PREFETCH_BASE_LOW = 8'h24;
    localparam logic [7:0] OFS_PREFETCH_LIMIT_LOW = 8'h26;
    localparam logic [7:0] OFS_PREFETCH_BASE_HIGH = 8'h28;
    localparam logic [7:0] OFS_PREFETCH_LIMIT_HIGH = 8'h2C;

    // ****************************************************************
    // reset values and read-only nibbles
    // ****************************************************************
    localparam logic [15:0] NONPREFETCH_BASE_RST = 16'hFFF0;
    localparam logic [15:0] NONPREFETCH_LIMIT_RST = 16'h0000;
    localparam logic [15:0] PREFETCH_BASE_LOW_RST = 16'hFFF1;
    localparam logic [15:0] PREFETCH_LIMIT_LOW_RST = 16'h0001;
    localparam logic [31:0] PREFETCH_HIGH_RST = 32'h0000_0000;
    localparam logic [3:0] NONPREFETCH_TYPE = 4'h0;
    localparam logic [3:0] PREFETCH_TYPE_64 = 4'h1;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef enum logic [1:0] {
        ROUTE_LOCAL,
        ROUTE_NONPREFETCH,
        ROUTE_PREFETCH
    } route_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] offset;
        logic [3:0] byte_en;
        logic [31:0] wdata;
    } cfg_req_t;

    typedef struct packed {
        logic valid;
        logic [31:0] rdata;
    } cfg_rsp_t;

    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] addr;
    } mem_req_t;

    typedef struct packed {
        logic valid;
        route_t route;
        logic [ADDR_W-1:0] addr;
    } mem_route_t;

endpackage

// ### hdl/window_match.sv
// inclusive address window compare on 1 MB granules
`timescale 1ns/1ps
module window_match #(
    parameter int ADDR_W = 40,
    parameter int BLOCK_BITS = 20
) (
    // request address
    input wire logic [ADDR_W-1:0] addr,
    // window bounds, address bits above the 1 MB granule
    input wire logic [ADDR_W-BLOCK_BITS-1:0] base_top,
    input wire logic [ADDR_W-BLOCK_BITS-1:0] limit_top,
    // result
    output logic hit
);
    wire [ADDR_W-1:0] base_full;
    wire [ADDR_W-1:0] limit_full;
    wire above_base;
    wire below_limit;

    // base granule starts at offset zero
    assign base_full = {base_top, {BLOCK_BITS{1'b0}}};
    // limit granule runs to its last byte
    assign limit_full = {limit_top, {BLOCK_BITS{1'b1}}};
    assign above_base = addr >= base_full;
    assign below_limit = addr <= limit_full;
    // an inverted window (base above limit) never hits
    assign hit = above_base && below_limit;
endmodule

// ### hdl/bridge_memory_window_decode.sv
// memory window decoder of the virtual bridge to the graphics express port
//
// What this block does
// - non-prefetchable hit when base <= address <= limit
// - base fields hold A[31:20], low bits zero
// - limit low twenty address bits read as ones
// - non-prefetchable low nibble reads zero, ignores writes
// - prefetchable hit on full-width inclusive compare
// - prefetch A[39:32] from upper registers low byte
// - prefetch base low nibble reads 1h
// - prefetch limit low nibble reads 1h
// - upper base register fully writable, resets zero
// - upper limit register fully writable, resets zero
`timescale 1ns/1ps
module bridge_memory_window_decode (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // configuration space access
    input wire bridge_window_pkg::cfg_req_t cfg_req,
    output bridge_window_pkg::cfg_rsp_t cfg_rsp,
    // processor memory requests
    input wire bridge_window_pkg::mem_req_t mem_req,
    output bridge_window_pkg::mem_route_t mem_route
);
    import bridge_window_pkg::*;

    // ****************************************************************
    // helpers
    // ****************************************************************

    // byte-lane update of a 12-bit field living in bits 15:4 of a half word
    function automatic logic [FIELD_W-1:0] merge_field(
        input logic [FIELD_W-1:0] old_val,
        input logic [15:0] wdata,
        input logic [1:0] be
    );
        logic [FIELD_W-1:0] res;
        res = old_val;
        if (be[0]) begin
            res[3:0] = wdata[7:FIELD_LSB];
        end
        if (be[1]) begin
            res[FIELD_W-1:4] = wdata[15:8];
        end
        return res;
    endfunction

    // byte-lane update of a full word
    function automatic logic [31:0] merge_word(
        input logic [31:0] old_val,
        input logic [31:0] wdata,
        input logic [3:0] be
    );
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[8*i +: 8] = wdata[8*i +: 8];
            end
        end
        return res;
    endfunction

    // does the request's dword offset match a register's offset
    function automatic logic dword_hit(input logic [7:0] ofs, input logic [7:0] reg_ofs);
        return ofs[7:2] == reg_ofs[7:2];
    endfunction

    // does a write enable either byte of the chosen half word
    function automatic logic half_enabled(input logic [3:0] be, input logic upper);
        return upper ? (be[3:2] != 2'h0) : (be[1:0] != 2'h0);
    endfunction

    // ****************************************************************
    // configuration decode
    // ****************************************************************
    wire cfg_wr;
    wire cfg_rd_take;
    wire sel_np_dword;
    wire sel_pf_low_dword;
    wire sel_pf_base_high;
    wire sel_pf_limit_high;
    wire wr_np_base;
    wire wr_np_limit;
    wire wr_pf_base_low;
    wire wr_pf_limit_low;
    wire wr_pf_base_high;
    wire wr_pf_limit_high;

    assign cfg_wr = cfg_req.valid && cfg_req.write;
    assign cfg_rd_take = cfg_req.valid && !cfg_req.write;
    assign sel_np_dword = dword_hit(cfg_req.offset, OFS_NONPREFETCH_BASE);
    assign sel_pf_low_dword = dword_hit(cfg_req.offset, OFS_PREFETCH_BASE_LOW);
    assign sel_pf_base_high = dword_hit(cfg_req.offset, OFS_PREFETCH_BASE_HIGH);
    assign sel_pf_limit_high = dword_hit(cfg_req.offset, OFS_PREFETCH_LIMIT_HIGH);

    // base sits in the low half of its dword, limit in the high half
    // a half word with no byte enabled keeps its register untouched
    assign wr_np_base = cfg_wr && sel_np_dword && half_enabled(cfg_req.byte_en, 1'b0);
    assign wr_np_limit = cfg_wr && sel_np_dword && half_enabled(cfg_req.byte_en, 1'b1);
    assign wr_pf_base_low = cfg_wr && sel_pf_low_dword && half_enabled(cfg_req.byte_en, 1'b0);
    assign wr_pf_limit_low = cfg_wr && sel_pf_low_dword && half_enabled(cfg_req.byte_en, 1'b1);
    assign wr_pf_base_high = cfg_wr && sel_pf_base_high && (cfg_req.byte_en != 4'h0);
    assign wr_pf_limit_high = cfg_wr && sel_pf_limit_high && (cfg_req.byte_en != 4'h0);

    // ****************************************************************
    // window registers
    // ****************************************************************
    // only the writable fields are stored; the low nibbles are constants,
    // so no write can ever reach them
    logic [FIELD_W-1:0] np_base_q;
    logic [FIELD_W-1:0] np_limit_q;
    logic [FIELD_W-1:0] pf_base_low_q;
    logic [FIELD_W-1:0] pf_limit_low_q;
    logic [HIGH_W-1:0] pf_base_high_q;
    logic [HIGH_W-1:0] pf_limit_high_q;
    logic [FIELD_W-1:0] np_base_d;
    logic [FIELD_W-1:0] np_limit_d;
    logic [FIELD_W-1:0] pf_base_low_d;
    logic [FIELD_W-1:0] pf_limit_low_d;
    logic [HIGH_W-1:0] pf_base_high_d;
    logic [HIGH_W-1:0] pf_limit_high_d;

    assign np_base_d = wr_np_base ?
        merge_field(np_base_q, cfg_req.wdata[15:0], cfg_req.byte_en[1:0]) : np_base_q;
    assign np_limit_d = wr_np_limit ?
        merge_field(np_limit_q, cfg_req.wdata[31:16], cfg_req.byte_en[3:2]) : np_limit_q;
    assign pf_base_low_d = wr_pf_base_low ?
        merge_field(pf_base_low_q, cfg_req.wdata[15:0], cfg_req.byte_en[1:0]) : pf_base_low_q;
    assign pf_limit_low_d = wr_pf_limit_low ?
        merge_field(pf_limit_low_q, cfg_req.wdata[31:16], cfg_req.byte_en[3:2]) : pf_limit_low_q;
    assign pf_base_high_d = wr_pf_base_high ?
        merge_word(pf_base_high_q, cfg_req.wdata, cfg_req.byte_en) : pf_base_high_q;
    assign pf_limit_high_d = wr_pf_limit_high ?
        merge_word(pf_limit_high_q, cfg_req.wdata, cfg_req.byte_en) : pf_limit_high_q;

    // one short flop per register keeps each reset value beside its field
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            np_base_q <= NONPREFETCH_BASE_RST[15:FIELD_LSB];
        end else if (clk_en) begin
            np_base_q <= np_base_d;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            np_limit_q <= NONPREFETCH_LIMIT_RST[15:FIELD_LSB];
        end else if (clk_en) begin
            np_limit_q <= np_limit_d;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pf_base_low_q <= PREFETCH_BASE_LOW_RST[15:FIELD_LSB];
        end else if (clk_en) begin
            pf_base_low_q <= pf_base_low_d;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pf_limit_low_q <= PREFETCH_LIMIT_LOW_RST[15:FIELD_LSB];
        end else if (clk_en) begin
            pf_limit_low_q <= pf_limit_low_d;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pf_base_high_q <= PREFETCH_HIGH_RST;
        end else if (clk_en) begin
            pf_base_high_q <= pf_base_high_d;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pf_limit_high_q <= PREFETCH_HIGH_RST;
        end else if (clk_en) begin
            pf_limit_high_q <= pf_limit_high_d;
        end
    end

    // ****************************************************************
    // configuration read
    // ****************************************************************
    wire [15:0] np_base_view;
    wire [15:0] np_limit_view;
    wire [15:0] pf_base_low_view;
    wire [15:0] pf_limit_low_view;
    wire [31:0] read_word;
    logic rsp_valid_q;
    logic [31:0] rsp_rdata_q;
    cfg_rsp_t cfg_rsp_d;

    assign np_base_view = {np_base_q, NONPREFETCH_TYPE};
    assign np_limit_view = {np_limit_q, NONPREFETCH_TYPE};
    assign pf_base_low_view = {pf_base_low_q, PREFETCH_TYPE_64};
    assign pf_limit_low_view = {pf_limit_low_q, PREFETCH_TYPE_64};

    assign read_word = sel_np_dword ? {np_limit_view, np_base_view} :
                       sel_pf_low_dword ? {pf_limit_low_view, pf_base_low_view} :
                       sel_pf_base_high ? pf_base_high_q :
                       sel_pf_limit_high ? pf_limit_high_q :
                       UNMAPPED_READ;

    // reads answer one cycle later with the whole dword; writes are not answered
    assign cfg_rsp_d.valid = cfg_rd_take;
    assign cfg_rsp_d.rdata = cfg_rd_take ? read_word : rsp_rdata_q;

    // valid is high for one enabled cycle per read, and holds while clk_en is low
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rsp_valid_q <= 1'b0;
        end else if (clk_en) begin
            rsp_valid_q <= cfg_rsp_d.valid;
        end
    end

    // rdata outlives the pulse so a late reader still sees the last answer
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rsp_rdata_q <= 32'h0000_0000;
        end else if (clk_en) begin
            rsp_rdata_q <= cfg_rsp_d.rdata;
        end
    end

    assign cfg_rsp = '{valid: rsp_valid_q, rdata: rsp_rdata_q};

    // ****************************************************************
    // window bounds
    // ****************************************************************
    wire [TOP_W-1:0] np_base_top;
    wire [TOP_W-1:0] np_limit_top;
    wire [TOP_W-1:0] pf_base_top;
    wire [TOP_W-1:0] pf_limit_top;
    wire [HIGH_USED_W-1:0] pf_base_upper;
    wire [HIGH_USED_W-1:0] pf_limit_upper;
    wire np_hit;
    wire pf_hit;

    // the non-prefetchable window lives below 4 GB, so its upper bits are zero
    assign np_base_top = {{HIGH_USED_W{1'b0}}, np_base_q};
    assign np_limit_top = {{HIGH_USED_W{1'b0}}, np_limit_q};
    // upper bits beyond the address width are stored but never compared
    assign pf_base_upper = pf_base_high_q[HIGH_USED_W-1:0];
    assign pf_limit_upper = pf_limit_high_q[HIGH_USED_W-1:0];
    assign pf_base_top = {pf_base_upper, pf_base_low_q};
    assign pf_limit_top = {pf_limit_upper, pf_limit_low_q};

    window_match #(
        .ADDR_W(ADDR_W),
        .BLOCK_BITS(BLOCK_BITS)
    ) u_np_match (
        .addr(mem_req.addr),
        .base_top(np_base_top),
        .limit_top(np_limit_top),
        .hit(np_hit)
    );

    window_match #(
        .ADDR_W(ADDR_W),
        .BLOCK_BITS(BLOCK_BITS)
    ) u_pf_match (
        .addr(mem_req.addr),
        .base_top(pf_base_top),
        .limit_top(pf_limit_top),
        .hit(pf_hit)
    );

    // ****************************************************************
    // routing decision
    // ****************************************************************
    // overlapping windows are a software fault; the non-prefetchable
    // window wins so the result is at least deterministic
    route_t route_sel;
    mem_route_t mem_route_q;
    mem_route_t mem_route_d;

    assign route_sel = np_hit ? ROUTE_NONPREFETCH :
                       pf_hit ? ROUTE_PREFETCH :
                       ROUTE_LOCAL;

    assign mem_route_d.valid = mem_req.valid;
    assign mem_route_d.route = mem_req.valid ? route_sel : ROUTE_LOCAL;
    assign mem_route_d.addr = mem_req.valid ? mem_req.addr : mem_route_q.addr;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            mem_route_q <= '{valid: 1'b0, route: ROUTE_LOCAL, addr: '0};
        end else if (clk_en) begin
            mem_route_q <= mem_route_d;
        end
    end

    assign mem_route = mem_route_q;
endmodule

// ### sim/window_checker.sv
// assertion checker for the memory window decoder ports
`timescale 1ns/1ps
module window_checker (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // ports watched
    input wire bridge_window_pkg::cfg_req_t cfg_req,
    input wire bridge_window_pkg::cfg_rsp_t cfg_rsp,
    input wire bridge_window_pkg::mem_req_t mem_req,
    input wire bridge_window_pkg::mem_route_t mem_route
);
    import bridge_window_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // ****************************************************************
    // shadow of the last read dword and the non-prefetchable window
    // ****************************************************************
    logic [5:0] rd_dw_q;
    logic [31:0] np_q;
    wire take_cfg = clk_en && cfg_req.valid;
    wire wr_np = take_cfg && cfg_req.write && cfg_req.offset[7:2] == 6'h08;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_dw_q <= 6'h00;
            np_q <= {NONPREFETCH_LIMIT_RST, NONPREFETCH_BASE_RST};
        end else begin
            if (take_cfg && !cfg_req.write) rd_dw_q <= cfg_req.offset[7:2];
            for (int i = 0; i < 4; i++) begin
                if (wr_np && cfg_req.byte_en[i]) np_q[8*i +: 8] <= cfg_req.wdata[8*i +: 8];
            end
        end
    end
    // ****************************************************************
    // assertions
    // ****************************************************************
    chk_read_answer: assert property (take_cfg && !cfg_req.write |=> cfg_rsp.valid)
        else $error("config read not answered next cycle");
    chk_np_nibble_zero: assert property (cfg_rsp.valid && rd_dw_q == 6'h08 |->
        cfg_rsp.rdata[3:0] == 4'h0 && cfg_rsp.rdata[19:16] == 4'h0) else $error("np nibble not zero");
    chk_pf_nibble_one: assert property (cfg_rsp.valid && rd_dw_q == 6'h09 |->
        cfg_rsp.rdata[3:0] == 4'h1 && cfg_rsp.rdata[19:16] == 4'h1) else $error("pf nibble not one");
    chk_np_hit: assert property (clk_en && mem_req.valid &&
        mem_req.addr[39:32] == 8'h00 && mem_req.addr[31:20] >= np_q[15:4] && mem_req.addr[31:20] <= np_q[31:20]
        |=> mem_route.route == ROUTE_NONPREFETCH) else $error("np window address not routed");
    // a route frozen by a low enable may outlive a window change, so only a fresh route is judged
    chk_np_bounds: assert property (mem_route.route == ROUTE_NONPREFETCH && $past(clk_en) |->
        mem_route.addr[31:20] >= $past(np_q[15:4]) && mem_route.addr[31:20] <= $past(np_q[31:20]))
        else $error("np route outside window");
    chk_np_low_space: assert property (mem_route.route == ROUTE_NONPREFETCH |->
        mem_route.addr[39:32] == 8'h00) else $error("np route above 4 GB");
    chk_route_follow: assert property (clk_en && mem_req.valid |=>
        mem_route.valid && mem_route.addr == $past(mem_req.addr)) else $error("request not routed");
    chk_idle_local: assert property (!mem_route.valid |-> mem_route.route == ROUTE_LOCAL)
        else $error("route kind without valid");
    cover property (mem_route.valid && mem_route.route == ROUTE_NONPREFETCH);
    cover property (mem_route.valid && mem_route.route == ROUTE_PREFETCH);
    cover property (cfg_rsp.valid && rd_dw_q == 6'h09);
endmodule
bind bridge_memory_window_decode window_checker u_chk (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en),
    .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .mem_req(mem_req), .mem_route(mem_route));

// ### sim/express_port_sink.sv
// downstream express port model: tallies forwarded requests by kind
`timescale 1ns/1ps
module express_port_sink (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // routed requests
    input wire bridge_window_pkg::mem_route_t mem_route,
    // tallies
    output logic [15:0] np_count,
    output logic [15:0] pf_count
);
    import bridge_window_pkg::*;
    // counts every cycle valid is high, so keep the clock enabled while a result shows
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            np_count <= 16'h0000;
            pf_count <= 16'h0000;
        end else if (mem_route.valid) begin
            np_count <= np_count + 16'(mem_route.route == ROUTE_NONPREFETCH);
            pf_count <= pf_count + 16'(mem_route.route == ROUTE_PREFETCH);
        end
    end
endmodule

// ### sim/testbench.sv
// self-checking bench for the memory window decoder
`timescale 1ns/1ps
module testbench;
    import bridge_window_pkg::*;
    logic ref_clk;
    logic arst_n;
    logic clk_en;
    cfg_req_t cfg_req;
    cfg_rsp_t cfg_rsp;
    mem_req_t mem_req;
    mem_route_t mem_route;
    logic [15:0] np_count;
    logic [15:0] pf_count;
    int failures;
    int checks;
    int seed;
    int exp_np;
    int exp_pf;
    logic [31:0] regs [4];
    logic [31:0] rd_q [$];
    logic [41:0] rt_q [$];
    logic [39:0] edges [9] = '{40'h00_0FFF_FFFF, 40'h00_1000_0000, 40'h00_1FFF_FFFF, 40'h00_2000_0000,
        40'h01_1FFF_FFFF, 40'h01_2000_0000, 40'h02_40FF_FFFF, 40'h02_4100_0000, 40'h01_1000_0000};
    bridge_memory_window_decode DUT (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en),
        .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .mem_req(mem_req), .mem_route(mem_route));
    express_port_sink u_sink (.ref_clk(ref_clk), .arst_n(arst_n), .mem_route(mem_route),
        .np_count(np_count), .pf_count(pf_count));
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // ****************************************************************
    // reference decode, drivers, compares
    // ****************************************************************
    function automatic route_t decode(input logic [39:0] x);
        logic np;
        logic pf;
        np = x[39:32] == 8'h00 && x[31:20] >= regs[0][15:4] && x[31:20] <= regs[0][31:20];
        pf = x >= {regs[2][7:0], regs[1][15:4], 20'h0} && x <= {regs[3][7:0], regs[1][31:20], 20'hFFFFF};
        return np ? ROUTE_NONPREFETCH : (pf ? ROUTE_PREFETCH : ROUTE_LOCAL);
    endfunction
    task automatic cfg_wr(input logic [7:0] o, input logic [3:0] be, input logic [31:0] d);
        @(posedge ref_clk);
        cfg_req <= '{1'b1, 1'b1, o, be, d};
        mem_req.valid <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (o[7:4] == 4'h2 && be[i]) regs[o[3:2]][8*i +: 8] = d[8*i +: 8];
        end
        regs[0] = regs[0] & 32'hFFF0FFF0;
        regs[1] = (regs[1] & 32'hFFF0FFF0) | 32'h00010001;
    endtask
    task automatic cfg_rd(input logic [7:0] o);
        @(posedge ref_clk);
        cfg_req <= '{1'b1, 1'b0, o, 4'h0, 32'h0};
        mem_req.valid <= 1'b0;
        rd_q.push_back(o[7:4] == 4'h2 ? regs[o[3:2]] : UNMAPPED_READ);
    endtask
    task automatic mem_send(input logic [39:0] x);
        route_t r;
        @(posedge ref_clk);
        r = decode(x);
        mem_req <= '{1'b1, x};
        cfg_req.valid <= 1'b0;
        rt_q.push_back({r, x});
        exp_np += int'(r == ROUTE_NONPREFETCH);
        exp_pf += int'(r == ROUTE_PREFETCH);
    endtask
    task automatic idle();
        @(posedge ref_clk);
        cfg_req.valid <= 1'b0;
        mem_req.valid <= 1'b0;
    endtask
    task automatic cmp_rd(input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED config data expected %h seen %h", exp, got);
        end
    endtask
    task automatic cmp_route(input logic [41:0] exp, input logic [41:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED route expected %h seen %h", exp, got);
        end
    endtask
    task automatic cmp_count(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(negedge ref_clk) begin
        if (arst_n && cfg_rsp.valid === 1'b1) begin
            cmp_rd(rd_q.size() ? rd_q.pop_front() : 'x, cfg_rsp.rdata);
        end
        if (arst_n && mem_route.valid === 1'b1) begin
            cmp_route(rt_q.size() ? rt_q.pop_front() : 'x, {mem_route.route, mem_route.addr});
        end
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        failures++;
        tally_and_finish();
    end
    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        seed = 69964;
        {failures, checks, exp_np, exp_pf} = '0;
        {arst_n, clk_en, cfg_req, mem_req} = '0;
        regs = '{{NONPREFETCH_LIMIT_RST, NONPREFETCH_BASE_RST}, {PREFETCH_LIMIT_LOW_RST, PREFETCH_BASE_LOW_RST},
            PREFETCH_HIGH_RST, PREFETCH_HIGH_RST};
        repeat (6) @(posedge ref_clk);
        arst_n <= 1'b1;
        clk_en <= 1'b1;
        // reset values, unmapped dwords, reset windows forward nothing
        for (int i = 0; i < 6; i++) cfg_rd(8'h1C + 8'(4 * i));
        for (int i = 0; i < 9; i++) mem_send(edges[i]);
        // all ones, then partial and empty byte enables, then an unmapped write
        for (int i = 0; i < 4; i++) cfg_wr(8'h20 + 8'(4 * i), 4'hF, 32'hFFFF_FFFF);
        cfg_wr(8'h20, 4'h3, 32'($random(seed)));
        cfg_wr(8'h24, 4'h0, 32'h0);
        cfg_wr(8'h30, 4'hF, 32'hFFFF_FFFF);
        for (int i = 0; i < 5; i++) cfg_rd(8'h20 + 8'(4 * i));
        // disjoint windows programmed before use
        cfg_wr(8'h20, 4'hF, 32'h1FF0_1000);
        cfg_wr(8'h24, 4'hF, 32'h40F0_2000);
        cfg_wr(8'h28, 4'hF, 32'hABCD_EF01);
        cfg_wr(8'h2C, 4'hF, 32'h0000_0002);
        for (int i = 0; i < 9; i++) mem_send(edges[i]);
        for (int i = 0; i < 300; i++) begin
            case ($unsigned($random(seed)) % 3)
                0: cfg_rd(8'($random(seed)));
                1: cfg_wr(8'h28 + 8'(4 * ($unsigned($random(seed)) % 2)), 4'hE, 32'($random(seed)));
                default: mem_send({6'h00, 2'($random(seed)), 32'($random(seed))});
            endcase
        end
        // a request held through a frozen clock enable is taken once
        repeat (3) idle();
        clk_en <= 1'b0;
        mem_send(40'h00_1234_5678);
        repeat (3) @(posedge ref_clk);
        clk_en <= 1'b1;
        repeat (4) idle();
        cmp_count("np routes", exp_np, {16'h0000, np_count});
        cmp_count("pf routes", exp_pf, {16'h0000, pf_count});
        cmp_count("pending notes", 32'h0000_0000, 32'(rd_q.size() + rt_q.size()));
        tally_and_finish();
    end
endmodule
